// [core/sos_top.sv]
/*
 * Sequence option switch decoder: register file, alarm and overtravel stop
 * sequencer, indicator output, error counter clear and mode switch control.
 * Assumes pin inputs are asynchronous and measurements come from the clk domain.
 */
`default_nettype none

// Overview of operation
// R1 - Bit 4 selects indicator: running (0) or torque limiting (1).
// R2 - Bit 5 set clears alarm automatically on power recovery; else alarm stays.
// R3 - Alarm stop uses dynamic brake when bit 6 is 0, coasting when 1.
// R4 - After alarm brake stop, bit 7 clear releases brake; set keeps it applied.
// R5 - Overtravel stop follows bit 6 when bit 8 is 0; else torque decel.
// R6 - After torque overtravel stop: servo off if bit 9 clear, zero-clamp if set.
// R7 - At servo off, error count cleared if bit A is 0, kept if 1.
// R8 - Bit B clear enables mode switch with trigger from bits D and C.
// R9 - D,C select torque, speed, acceleration or error pulse comparison.
// R10 - Four level constants with defaults 200, 0, 0 and 10000.
// R11 - Bits 2 and 3 ignore forward or reverse travel limit inputs.
// R12 - Above level the speed loop goes P-only; below level back to PI.
// R13 - Switch word applied only when no stop sequence is in progress.
module sos_top
	import sos_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Pin inputs
	input wire logic forward_travel_limit,
	input wire logic reverse_travel_limit,
	input wire logic alarm_in,
	input wire logic power_restored,
	input wire logic servo_on_req,
	// Drive feedback
	input wire logic motor_running,
	input wire logic motor_stopped,
	input wire logic torque_limiting,
	input wire sos_meas_t meas,
	// Drive controls
	output logic motion_indicator_output,
	output logic servo_enable,
	output logic dyn_brake,
	output logic torque_decel,
	output logic [15:0] emergency_stop_torque,
	output logic zero_clamp,
	output logic clear_error_count,
	output logic alarm_active,
	output logic p_only_loop,
	output logic irq
);

	logic [15:0] sequence_option_switches;
	logic [15:0] pending_switches;
	logic pending;
	sos_levels_t levels;
	logic [15:0] estop_trq;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] events;
	sos_state_t state;
	sos_state_t next_state;
	logic [7:0] settle;
	logic [4:0] pins;
	logic fwd_lim, rev_lim, alarm_pin, pwr_back, son;
	logic pwr_back_d;
	logic alarm_latched;
	logic overtravel;
	logic servo_on_d;
	logic msw_p;
	logic msw_p_d;
	logic stop_done;

	sos_sync #(
		.W(5)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in({forward_travel_limit, reverse_travel_limit, alarm_in, power_restored,
			servo_on_req}),
		.sync_out(pins)
	);
	assign {fwd_lim, rev_lim, alarm_pin, pwr_back, son} = pins;

	sos_mode_switch u_msw (
		.clk(clk),
		.rst_n(rst_n),
		.enable(!sequence_option_switches[BIT_MSW_OFF]), // R8
		.sel(sos_msw_sel_t'(sequence_option_switches[BIT_MSW_SEL_LO +: 2])), // R9
		.levels(levels),
		.meas(meas),
		.p_only(msw_p)
	);

	// Ignored limit inputs always permit travel in that direction.
	assign overtravel = (fwd_lim && !sequence_option_switches[BIT_FWD_LIMIT_OFF]) ||
		(rev_lim && !sequence_option_switches[BIT_REV_LIMIT_OFF]); // R11

	assign stop_done = (settle == STOP_SETTLE_CYC);

	// ==========================================================
	// Register writes
	// A new switch word waits in a holding register while a stop runs, so
	// the stop method cannot change under a motor that is already stopping.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sequence_option_switches <= SWITCHES_RESET;
			pending_switches <= SWITCHES_RESET;
			pending <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_SWITCHES) begin
			pending_switches <= reg_wdata;
			pending <= 1'b1;
		end else if (pending && state == ST_RUN) begin
			sequence_option_switches <= pending_switches; // R13
			pending <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			levels <= {TRQ_LVL_RESET, SPD_LVL_RESET, ACC_LVL_RESET, ERR_LVL_RESET}; // R10
			estop_trq <= ESTOP_TRQ_RESET;
			irq_mask <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_TRQ_LVL: levels.torque <= reg_wdata;
				ADDR_SPD_LVL: levels.speed <= reg_wdata;
				ADDR_ACC_LVL: levels.accel <= reg_wdata;
				ADDR_ERR_LVL: levels.error <= reg_wdata;
				ADDR_ESTOP_TRQ: estop_trq <= reg_wdata;
				ADDR_IRQ_MASK: irq_mask <= reg_wdata[IRQ_WIDTH-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Register reads
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_SWITCHES: reg_rdata <= pending ? pending_switches :
					sequence_option_switches;
				ADDR_TRQ_LVL: reg_rdata <= levels.torque;
				ADDR_SPD_LVL: reg_rdata <= levels.speed;
				ADDR_ACC_LVL: reg_rdata <= levels.accel;
				ADDR_ERR_LVL: reg_rdata <= levels.error;
				ADDR_ESTOP_TRQ: reg_rdata <= estop_trq;
				ADDR_STATUS: reg_rdata <= {8'h00, pending, msw_p, overtravel, alarm_latched,
					3'(state == ST_BRAKE ? 3'h1 : state == ST_COAST ? 3'h2 :
					state == ST_DECEL ? 3'h3 : state == ST_HALT ? 3'h4 : 3'h0),
					servo_enable};
				ADDR_IRQ_MASK: reg_rdata <= {12'h000, irq_mask};
				ADDR_IRQ_STATUS: reg_rdata <= {12'h000, irq_status};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================================
	// Alarm latch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwr_back_d <= 1'b0;
			alarm_latched <= 1'b0;
		end else begin
			pwr_back_d <= pwr_back;
			if (alarm_pin) begin
				alarm_latched <= 1'b1;
			end else if (pwr_back && !pwr_back_d &&
				sequence_option_switches[BIT_AUTO_RESET]) begin
				alarm_latched <= 1'b0; // R2
			end
		end
	end

	// ==========================================================
	// Stop sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN: begin
				if (alarm_latched) begin
					next_state = sequence_option_switches[BIT_ALARM_COAST] ? ST_COAST :
						ST_BRAKE; // R3
				end else if (overtravel) begin
					if (sequence_option_switches[BIT_OT_TORQUE]) begin
						next_state = ST_DECEL; // R5
					end else begin
						next_state = sequence_option_switches[BIT_ALARM_COAST] ? ST_COAST :
							ST_BRAKE; // R5
					end
				end
			end
			ST_BRAKE, ST_COAST: begin
				if (stop_done) begin
					next_state = ST_HALT;
				end
			end
			ST_DECEL: begin
				if (stop_done) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (!alarm_latched && !overtravel) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ST_RUN;
			settle <= '0;
		end else begin
			state <= next_state;
			if (next_state != state || !motor_stopped) begin
				settle <= '0;
			end else if (!stop_done) begin
				settle <= 8'(settle + 8'h01);
			end
		end
	end

	// ==========================================================
	// Drive outputs
	// Halt after a torque stop is recorded so the zero-clamp choice applies.
	logic halt_from_decel;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halt_from_decel <= 1'b0;
		end else if (state == ST_DECEL) begin
			halt_from_decel <= 1'b1;
		end else if (state == ST_RUN || state == ST_BRAKE || state == ST_COAST) begin
			halt_from_decel <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			servo_enable <= 1'b0;
			dyn_brake <= 1'b0;
			torque_decel <= 1'b0;
			zero_clamp <= 1'b0;
			emergency_stop_torque <= '0;
			alarm_active <= 1'b0;
		end else begin
			alarm_active <= alarm_latched;
			torque_decel <= (state == ST_DECEL); // R5
			emergency_stop_torque <= (state == ST_DECEL) ? estop_trq : 16'h0000;
			dyn_brake <= (state == ST_BRAKE) ||
				(state == ST_HALT && !halt_from_decel && alarm_latched &&
				!sequence_option_switches[BIT_ALARM_COAST] &&
				sequence_option_switches[BIT_BRAKE_HOLD]); // R4
			zero_clamp <= (state == ST_HALT) && halt_from_decel &&
				sequence_option_switches[BIT_OT_CLAMP]; // R6
			servo_enable <= son && ((state == ST_RUN) || (state == ST_DECEL) ||
				(state == ST_HALT && halt_from_decel &&
				sequence_option_switches[BIT_OT_CLAMP])); // R6
		end
	end

	// ==========================================================
	// Indicator, error clear and loop mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			motion_indicator_output <= 1'b0;
			servo_on_d <= 1'b0;
			clear_error_count <= 1'b0;
			p_only_loop <= 1'b0;
			msw_p_d <= 1'b0;
		end else begin
			motion_indicator_output <= sequence_option_switches[BIT_IND_TORQUE] ?
				torque_limiting : motor_running; // R1
			servo_on_d <= servo_enable;
			clear_error_count <= servo_on_d && !servo_enable &&
				!sequence_option_switches[BIT_KEEP_ERROR]; // R7
			p_only_loop <= msw_p; // R12
			msw_p_d <= msw_p;
		end
	end

	// ==========================================================
	// Interrupts
	// Stop completion fires once, on the last cycle of a brake, coast or decel phase.
	assign events = {msw_p && !msw_p_d,
		(state != ST_RUN) && (state != ST_HALT) && stop_done, overtravel && state == ST_RUN,
		alarm_pin && !alarm_latched};

	// A read clears the status, but an event in the same cycle still lands.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			irq_status <= ((reg_rd && reg_addr == ADDR_IRQ_STATUS) ? '0 : irq_status) |
				events;
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

`default_nettype wire

// [core/sos_pkg.sv]
/*
 * Package for the sequence option switch decoder: register map, switch bit
 * positions, reset values, level constant defaults and carrier structs.
 * Assumes a single 20 MHz control clock and a plain strobe register port.
 */
`default_nettype none

package sos_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_SWITCHES = 4'h0;
	localparam logic [3:0] ADDR_TRQ_LVL = 4'h1;
	localparam logic [3:0] ADDR_SPD_LVL = 4'h2;
	localparam logic [3:0] ADDR_ACC_LVL = 4'h3;
	localparam logic [3:0] ADDR_ERR_LVL = 4'h4;
	localparam logic [3:0] ADDR_ESTOP_TRQ = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;

	// ==========================================================
	// Switch bit positions
	localparam int BIT_FWD_LIMIT_OFF = 2;
	localparam int BIT_REV_LIMIT_OFF = 3;
	localparam int BIT_IND_TORQUE = 4;
	localparam int BIT_AUTO_RESET = 5;
	localparam int BIT_ALARM_COAST = 6;
	localparam int BIT_BRAKE_HOLD = 7;
	localparam int BIT_OT_TORQUE = 8;
	localparam int BIT_OT_CLAMP = 9;
	localparam int BIT_KEEP_ERROR = 10;
	localparam int BIT_MSW_OFF = 11;
	localparam int BIT_MSW_SEL_LO = 12;

	// ==========================================================
	// Reset values
	localparam logic [15:0] SWITCHES_RESET = 16'h0080;
	localparam logic [15:0] TRQ_LVL_RESET = 16'h00c8;
	localparam logic [15:0] SPD_LVL_RESET = 16'h0000;
	localparam logic [15:0] ACC_LVL_RESET = 16'h0000;
	localparam logic [15:0] ERR_LVL_RESET = 16'h2710;
	localparam logic [15:0] ESTOP_TRQ_RESET = 16'h0064;

	// Interrupt event bit positions.
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_OVERTRAVEL = 1;
	localparam int IRQ_STOPPED = 2;
	localparam int IRQ_MODE_SWITCH = 3;
	localparam int IRQ_WIDTH = 4;

	// Settle count so a stop counts as finished only after a steady zero speed.
	localparam real STOP_SETTLE_US = 10.0;
	localparam real CLK_MHZ = 20.0;
	localparam logic [7:0] STOP_SETTLE_CYC = 8'($rtoi(STOP_SETTLE_US * CLK_MHZ));

	// ==========================================================
	// Mode switch trigger select
	typedef enum logic [1:0] {
		MSW_TORQUE = 2'h0,
		MSW_SPEED = 2'h1,
		MSW_ACCEL = 2'h2,
		MSW_ERROR = 2'h3
	} sos_msw_sel_t;

	// Stop sequencer states.
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_BRAKE = 5'h02,
		ST_COAST = 5'h04,
		ST_DECEL = 5'h08,
		ST_HALT = 5'h10
	} sos_state_t;

	typedef struct packed {
		logic [15:0] torque;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] error;
	} sos_levels_t;

	typedef struct packed {
		logic [15:0] torque_ref;
		logic [15:0] speed_ref;
		logic [15:0] accel;
		logic [15:0] error_count;
	} sos_meas_t;

	// Magnitude of a signed two's complement quantity.
	function automatic logic [15:0] sos_abs(input logic [15:0] v);
		return v[15] ? 16'(-v) : v;
	endfunction

endpackage

`default_nettype wire

// [core/sos_sync.sv]
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes inputs are asynchronous to clk.
 */
`default_nettype none

module sos_sync
	import sos_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta;

	// ==========================================================
	// Synchroniser
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule

`default_nettype wire

// [core/sos_mode_switch.sv]
/*
 * Mode switch comparator: picks the trigger quantity and compares it with
 * its level constant. Assumes measurements are in the clk domain.
 */
`default_nettype none

module sos_mode_switch
	import sos_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Selection
	input wire logic enable,
	input wire sos_msw_sel_t sel,
	input wire sos_levels_t levels,
	input wire sos_meas_t meas,
	// Result
	output logic p_only
);

	logic [15:0] value;
	logic [15:0] level;

	always_comb begin
		value = '0;
		level = '0;
		unique case (sel)
			MSW_TORQUE: begin
				value = sos_abs(meas.torque_ref); // R9
				level = levels.torque; // R10
			end
			MSW_SPEED: begin
				value = sos_abs(meas.speed_ref); // R9
				level = levels.speed;
			end
			MSW_ACCEL: begin
				value = sos_abs(meas.accel); // R9
				level = levels.accel;
			end
			MSW_ERROR: begin
				value = sos_abs(meas.error_count); // R9
				level = levels.error;
			end
		endcase
	end

	// ==========================================================
	// P-only while above the level; at the level the loop keeps its state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			p_only <= 1'b0;
		end else if (!enable) begin
			p_only <= 1'b0; // R8
		end else if (value > level) begin
			p_only <= 1'b1; // R12
		end else if (value < level) begin
			p_only <= 1'b0; // R12
		end
	end

endmodule

`default_nettype wire

// [bench/sos_top_properties.sv]
/*
 * Port checker for sos_top, bound into every instance of it.
 * Assumes one clock domain and the synchronous active-low reset.
 */
`default_nettype none

module sos_top_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Pins and feedback
	input wire logic alarm_in,
	input wire logic servo_on_req,
	input wire logic motor_running,
	input wire logic torque_limiting,
	// Drive controls
	input wire logic motion_indicator_output,
	input wire logic servo_enable,
	input wire logic dyn_brake,
	input wire logic torque_decel,
	input wire logic [15:0] emergency_stop_torque,
	input wire logic zero_clamp,
	input wire logic clear_error_count,
	input wire logic alarm_active,
	input wire logic p_only_loop
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Assertions
	a_rdata_idle:
		assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero:
		assert property (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 16'h0000)
		else $error("unmapped read returned data");
	a_ind_source:
		assert property (motion_indicator_output |-> $past(motor_running) || $past(torque_limiting))
		else $error("indicator high without a cause");
	a_alarm_cause:
		assert property ($rose(alarm_active) |-> $past(alarm_in, 3))
		else $error("alarm latched without alarm input");
	a_alarm_stop:
		assert property ($rose(alarm_active) |-> ##[0:4] !servo_enable)
		else $error("servo stayed on after alarm");
	a_brake_decel_excl:
		assert property (!(dyn_brake && torque_decel))
		else $error("brake and torque decel together");
	a_estop_idle:
		assert property (!torque_decel |-> emergency_stop_torque == 16'h0000)
		else $error("stop torque driven outside decel");
	a_clamp_brake:
		assert property (zero_clamp |-> !dyn_brake)
		else $error("zero clamp with brake applied");
	a_clear_pulse:
		assert property (clear_error_count |=> !clear_error_count)
		else $error("error clear longer than one cycle");
	a_clear_at_off:
		assert property (clear_error_count |-> ##[0:2] !servo_enable)
		else $error("error clear without servo off");
	a_servo_late:
		assert property ($rose(servo_enable) |-> $past(servo_on_req, 3))
		else $error("servo enabled too early");

	// ==========================================================
	// Coverage
	c_alarm: cover property ($rose(alarm_active));
	c_decel: cover property ($rose(torque_decel));
	c_p_only: cover property ($rose(p_only_loop));
	c_clear: cover property (clear_error_count);
endmodule

bind sos_top sos_top_properties u_props (.clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
	.alarm_in, .servo_on_req, .motor_running, .torque_limiting, .motion_indicator_output,
	.servo_enable, .dyn_brake, .torque_decel, .emergency_stop_torque, .zero_clamp,
	.clear_error_count, .alarm_active, .p_only_loop);

`default_nettype wire

// [bench/test_servo_sequence_option_switches.sv]
/*
 * Self-checking bench for sos_top: registers, stop sequences, interrupt,
 * error clear and mode switch. Assumes the package and design are compiled first.
 */
`default_nettype none

module test_servo_sequence_option_switches import sos_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic forward_travel_limit = 1'b0, reverse_travel_limit = 1'b0, alarm_in = 1'b0;
	logic power_restored = 1'b0, servo_on_req = 1'b0, motor_running = 1'b0;
	logic motor_stopped = 1'b0, torque_limiting = 1'b0;
	sos_meas_t meas = '0;
	logic motion_indicator_output, servo_enable, dyn_brake, torque_decel, zero_clamp, irq;
	logic clear_error_count, alarm_active, p_only_loop;
	logic [15:0] emergency_stop_torque, reg_rdata, rd_val, lv, v;
	logic [31:0] seed = 32'h80b7;
	int n_mismatch = 0, compares = 0, n;
	logic [3:0] ra [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, ADDR_ESTOP_TRQ, ADDR_IRQ_MASK, 4'hf};
	logic [15:0] re [8] = '{16'h0080, 16'h00c8, 16'h0000, 16'h0000, 16'h2710,
		ESTOP_TRQ_RESET, 16'h0000, 16'h0000};
	// Stop cases: switch word, cause (alarm, forward, reverse), expected outputs.
	logic [15:0] sw_tab [8] = '{16'h00a0, 16'h0020, 16'h0060, 16'h0120, 16'h0320, 16'h0020,
		16'h0124, 16'h0128};
	logic [4:0] ex_tab [8] = '{5'h0a, 5'h08, 5'h00, 5'h04, 5'h05, 5'h08, 5'h10, 5'h10};
	int src_tab [8] = '{0, 0, 0, 1, 2, 1, 1, 2};

	sos_top u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.forward_travel_limit, .reverse_travel_limit, .alarm_in, .power_restored,
		.servo_on_req, .motor_running, .motor_stopped, .torque_limiting, .meas,
		.motion_indicator_output, .servo_enable, .dyn_brake, .torque_decel,
		.emergency_stop_torque, .zero_clamp, .clear_error_count, .alarm_active,
		.p_only_loop, .irq);

	always #25 clk = ~clk;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction

	function automatic logic [15:0] mag(input logic [15:0] x);
		return x[15] ? 16'h0000 - x : x;
	endfunction

	function automatic logic probe(input int w);
		logic [7:0] b;
		b = {zero_clamp, clear_error_count, irq, alarm_active, p_only_loop, servo_enable,
			torque_decel, dyn_brake};
		return b[w];
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	// Polls an output under a bound and ends on a rising edge.
	task automatic await(input int w, input logic e, input int lim);
		int i;
		#1;
		for (i = 0; i < lim && probe(w) !== e; i++) begin
			@(posedge clk);
			#1;
		end
		chk(16'(probe(w)), 16'(e), "output did not settle");
		@(posedge clk);
	endtask

	task automatic stop_case(input logic [15:0] sw, input int src, input logic [4:0] ex);
		wr(ADDR_SWITCHES, sw);
		await(2, 1'b1, 20);
		motor_stopped <= 1'b0;
		if (src == 0) alarm_in <= 1'b1;
		if (src == 1) forward_travel_limit <= 1'b1;
		if (src == 2) reverse_travel_limit <= 1'b1;
		cyc(10);
		#1;
		chk(dyn_brake, ex[3], "brake during stop");
		chk(torque_decel, ex[2], "decel during stop");
		if (ex[2]) chk(emergency_stop_torque, ESTOP_TRQ_RESET, "stop torque");
		if (!ex[2]) chk(servo_enable, ex[4], "servo during stop");
		if (!ex[4]) begin
			// A new word mid-stop must wait for the run state.
			wr(ADDR_SWITCHES, sw ^ 16'h0140);
			rd(ADDR_SWITCHES);
			chk(rd_val, sw ^ 16'h0140, "pending readback");
			chk(dyn_brake, ex[3], "brake changed mid stop");
			// The toggled word stays pending through the halt; only in the 16'h00a0 case, where bit 7 holds
			// the brake, would the brake check below trip if it were applied before the sequencer returns to run.
			motor_stopped <= 1'b1;
			cyc(int'(STOP_SETTLE_CYC) + 20);
			#1;
			chk(dyn_brake, ex[1], "brake after stop");
			chk(zero_clamp, ex[0], "clamp after stop");
			chk(servo_enable, ex[0], "servo after stop");
		end
		@(posedge clk);
		alarm_in <= 1'b0;
		forward_travel_limit <= 1'b0;
		reverse_travel_limit <= 1'b0;
		cyc(4);
		power_restored <= 1'b1;
		cyc(4);
		power_restored <= 1'b0;
		await(4, 1'b0, 10);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk(rd_val, re[i], "reset value");
		end
		@(posedge clk);
		servo_on_req <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			if (k % 4 == 0) wr(ADDR_SWITCHES, k > 0 ? 16'h0090 : 16'h0080);
			seed = xs(seed);
			@(posedge clk);
			motor_running <= seed[0];
			torque_limiting <= seed[1];
			cyc(3);
			#1 chk(motion_indicator_output, k > 3 ? seed[1] : seed[0], "indicator");
		end
		wr(ADDR_IRQ_MASK, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			stop_case(sw_tab[i], src_tab[i], ex_tab[i]);
			if (i == 0) begin
				chk(irq, 1'b1, "irq not raised");
				rd(ADDR_IRQ_STATUS);
				chk(rd_val, 16'h0005, "irq status");
				await(5, 1'b0, 5);
				wr(ADDR_IRQ_MASK, 16'h0008);
			end
		end
		chk(irq, 1'b0, "masked event raised irq");
		rd(ADDR_IRQ_STATUS);
		chk(rd_val, 16'h0007, "masked events not recorded");
		for (int a = 0; a < 2; a++) begin
			wr(ADDR_SWITCHES, a > 0 ? 16'h0400 : 16'h0000);
			await(2, 1'b1, 20);
			servo_on_req <= 1'b0;
			n = 0;
			repeat (8) begin
				@(posedge clk);
				#1 n += clear_error_count;
			end
			chk(16'(n), a > 0 ? 16'h0000 : 16'h0001, "error clear pulse");
			@(posedge clk);
			servo_on_req <= 1'b1;
		end
		for (int s = 0; s < 5; s++) begin
			seed = xs(seed);
			lv = {6'h00, seed[9:0]} | 16'h0002;
			if (s < 4) begin
				wr(4'(s + 1), lv);
				rd(4'(s + 1));
				chk(rd_val, lv, "level readback");
			end
			wr(ADDR_SWITCHES, s < 4 ? 16'(s) << 12 : 16'h3800);
			for (int j = 0; j < 2; j++) begin
				v = j > 0 ? lv >> 1 : lv + 16'h0001 + 16'(seed[13:10]);
				if (seed[14]) v = 16'h0000 - v;
				@(posedge clk);
				meas <= 64'(v) << (16 * (3 - s % 4));
				await(3, s < 4 && mag(v) > lv, 12);
			end
		end
		end_of_test();
	end

	initial begin
		#1000000;
		n_mismatch++;
		end_of_test();
	end
endmodule

`default_nettype wire
